// file: design/rpc_pkg.sv
package rpc_pkg;

  localparam int unsigned RPC_ADDR_W = 8;
  localparam int unsigned RPC_DATA_W = 8;

  // Register offsets
  localparam logic [7:0] RPC_OFS_POWER_CTRL = 8'h87;
  localparam logic [7:0] RPC_OFS_MODE_CTRL = 8'h88;
  localparam logic [7:0] RPC_OFS_STATUS = 8'h89;

  // power_control_reg fields
  localparam int unsigned RPC_BIT_IDLE = 0;
  localparam int unsigned RPC_BIT_PWRDN = 1;
  localparam int unsigned RPC_BIT_GF0 = 2;
  localparam int unsigned RPC_BIT_GF1 = 3;

  // mode control fields
  localparam int unsigned RPC_BIT_ADC_IDLE = 0;
  localparam int unsigned RPC_BIT_IRQ0_EN = 1;
  localparam int unsigned RPC_BIT_IRQ1_EN = 2;

  // status fields
  localparam int unsigned RPC_BIT_ST_RESUME = 0;
  localparam int unsigned RPC_BIT_ST_CORE_RST = 1;
  localparam int unsigned RPC_BIT_ST_PD_WAKE = 2;
  localparam int unsigned RPC_BIT_ST_WDT_OUT = 3;
  localparam int unsigned RPC_BIT_ST_WARM_SEEN = 4;

  // Reset values
  localparam logic [7:0] RPC_RST_POWER_CTRL = 8'h00;
  localparam logic [7:0] RPC_RST_MODE_CTRL = 8'h00;

  // Timing, in oscillator periods (one i_clk each)
  localparam int unsigned RPC_WARM_RST_MIN_CYC = 24;
  localparam int unsigned RPC_WDT_PULSE_CYC = 96;
  localparam int unsigned RPC_CNT_W = 7;

  localparam logic [15:0] RPC_RESET_VECTOR = 16'h0000;

  typedef enum logic [3:0] {
    RPC_ST_RUN = 4'b0001,
    RPC_ST_RESUME = 4'b0010,
    RPC_ST_CORE_RST = 4'b0100,
    RPC_ST_PD_WAKE = 4'b1000
  } rpc_state_t;

endpackage

// file: design/rpc_sync.sv
`timescale 1ns/100ps
module rpc_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Data
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // First stage feeds only the second
  always_comb begin
    meta_d = i_rst ? INIT : i_async;
    sync_d = i_rst ? INIT : meta_q;
  end

  always_ff @(posedge i_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign o_sync = sync_q;

endmodule

// file: design/rpc_reset_idle_powerdown_ctrl.sv
`timescale 1ns/100ps
module rpc_reset_idle_powerdown_ctrl
  import rpc_pkg::*;
#(
  parameter int unsigned WARM_RST_MIN_CYC = RPC_WARM_RST_MIN_CYC,
  parameter int unsigned WDT_PULSE_CYC = RPC_WDT_PULSE_CYC
) (
  // Clock and synchronous reset
  input wire logic i_clk,
  input wire logic i_rst,
  // External reset pin, two-way
  input wire logic i_rst_pin,
  output logic o_rst_pin_o,
  output logic o_rst_pin_oe,
  // External interrupt pins, active low
  input wire logic i_ext_irq_zero_pin_n,
  input wire logic i_ext_irq_one_pin_n,
  // Events from the core and peripherals
  input wire logic i_watchdog_timer_expire,
  input wire logic i_irq_pending,
  input wire logic i_adc_done,
  // Register port
  input wire logic [RPC_ADDR_W-1:0] i_addr,
  input wire logic [RPC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [RPC_DATA_W-1:0] o_rdata,
  // Clock and reset controls toward the core
  output logic o_osc_en,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_state_hold,
  output logic o_cpu_rst,
  output logic [15:0] o_reset_vector,
  output logic o_ram_block
);

  localparam logic [RPC_CNT_W-1:0] WARM_LAST = RPC_CNT_W'(WARM_RST_MIN_CYC - 1);
  localparam logic [RPC_CNT_W-1:0] WDT_LAST = RPC_CNT_W'(WDT_PULSE_CYC - 1);

  function automatic logic hit(input logic [RPC_ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Pin synchronisers
  logic [2:0] pins_s;
  logic rst_pin_s;
  logic irq0_s_n;
  logic irq1_s_n;

  rpc_sync #(
    .WIDTH(3),
    .INIT(3'h6)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async({i_ext_irq_one_pin_n, i_ext_irq_zero_pin_n, i_rst_pin}),
    .o_sync(pins_s)
  );

  assign rst_pin_s = pins_s[0];
  assign irq0_s_n = pins_s[1];
  assign irq1_s_n = pins_s[2];

  // Mode bits and hold cleared, clock enables set, asynchronously by the reset pin
  logic idle_request_bit_q;
  logic idle_request_bit_d;
  logic powerdown_request_bit_q;
  logic powerdown_request_bit_d;
  logic osc_en_q;
  logic osc_en_d;
  logic cpu_clk_en_q;
  logic cpu_clk_en_d;
  logic periph_clk_en_q;
  logic periph_clk_en_d;
  logic hold_q;
  logic hold_d;

  // Software state
  logic general_flag_zero_q;
  logic general_flag_zero_d;
  logic general_flag_one_q;
  logic general_flag_one_d;
  logic adc_idle_q;
  logic adc_idle_d;
  logic irq0_en_q;
  logic irq0_en_d;
  logic irq1_en_q;
  logic irq1_en_d;
  logic [RPC_DATA_W-1:0] rdata_q;
  logic [RPC_DATA_W-1:0] rdata_d;

  // Reset sequencing state
  rpc_state_t state_q;
  rpc_state_t state_d;
  logic [RPC_CNT_W-1:0] warm_cnt_q;
  logic [RPC_CNT_W-1:0] warm_cnt_d;
  logic [RPC_CNT_W-1:0] wdt_cnt_q;
  logic [RPC_CNT_W-1:0] wdt_cnt_d;
  logic wdt_drive_q;
  logic wdt_drive_d;
  logic warm_seen_q;
  logic warm_seen_d;
  logic cpu_rst_q;
  logic cpu_rst_d;
  logic ram_block_q;
  logic ram_block_d;
  logic [15:0] vector_q;
  logic [15:0] vector_d;

  logic wr_power_control_reg;
  logic irq_wake;
  logic irq_pins_released;

  assign wr_power_control_reg = i_wr && hit(i_addr, RPC_OFS_POWER_CTRL);
  assign irq_wake = (irq0_en_q && !irq0_s_n) || (irq1_en_q && !irq1_s_n);
  assign irq_pins_released = (!irq0_en_q || irq0_s_n) && (!irq1_en_q || irq1_s_n);

  // Mode bits and clock gates
  always_comb begin
    idle_request_bit_d = idle_request_bit_q;
    powerdown_request_bit_d = powerdown_request_bit_q;
    if (i_rst) begin
      idle_request_bit_d = 1'b0;
      powerdown_request_bit_d = 1'b0;
    end else if (wr_power_control_reg) begin
      idle_request_bit_d = i_wdata[RPC_BIT_IDLE];
      powerdown_request_bit_d = i_wdata[RPC_BIT_PWRDN];
    end else begin
      if (idle_request_bit_q && i_irq_pending) begin
        // Core vectors to the handler and returns past the idle entry
        idle_request_bit_d = 1'b0;
      end
      if (idle_request_bit_q && adc_idle_q && i_adc_done) begin
        idle_request_bit_d = 1'b0;
      end
      if (powerdown_request_bit_q && irq_wake) begin
        // Only pins and reset leave power-down
        powerdown_request_bit_d = 1'b0;
      end
    end
    // Gates follow the next mode so entry takes effect on the writing cycle
    osc_en_d = !powerdown_request_bit_d;
    periph_clk_en_d = !powerdown_request_bit_d;
    // Core stays stopped after wake until the wake pin is released
    cpu_clk_en_d = !powerdown_request_bit_d && !idle_request_bit_d
                   && (state_d != RPC_ST_PD_WAKE);
    hold_d = powerdown_request_bit_d || (state_d == RPC_ST_PD_WAKE);
  end

  // Reset pin clears mode bits without waiting for a clock
  always_ff @(posedge i_clk or posedge i_rst_pin) begin
    if (i_rst_pin) begin
      idle_request_bit_q <= 1'b0;
      powerdown_request_bit_q <= 1'b0;
      osc_en_q <= 1'b1;
      periph_clk_en_q <= 1'b1;
      cpu_clk_en_q <= 1'b1;
      hold_q <= 1'b0;
    end else begin
      idle_request_bit_q <= idle_request_bit_d;
      powerdown_request_bit_q <= powerdown_request_bit_d;
      osc_en_q <= osc_en_d;
      periph_clk_en_q <= periph_clk_en_d;
      cpu_clk_en_q <= cpu_clk_en_d;
      hold_q <= hold_d;
    end
  end

  // Software registers
  always_comb begin
    general_flag_zero_d = general_flag_zero_q;
    general_flag_one_d = general_flag_one_q;
    adc_idle_d = adc_idle_q;
    irq0_en_d = irq0_en_q;
    irq1_en_d = irq1_en_q;
    rdata_d = '0;
    if (i_rst) begin
      general_flag_zero_d = RPC_RST_POWER_CTRL[RPC_BIT_GF0];
      general_flag_one_d = RPC_RST_POWER_CTRL[RPC_BIT_GF1];
      adc_idle_d = RPC_RST_MODE_CTRL[RPC_BIT_ADC_IDLE];
      irq0_en_d = RPC_RST_MODE_CTRL[RPC_BIT_IRQ0_EN];
      irq1_en_d = RPC_RST_MODE_CTRL[RPC_BIT_IRQ1_EN];
    end else begin
      if (wr_power_control_reg) begin
        general_flag_zero_d = i_wdata[RPC_BIT_GF0];
        general_flag_one_d = i_wdata[RPC_BIT_GF1];
      end
      if (i_wr && hit(i_addr, RPC_OFS_MODE_CTRL)) begin
        adc_idle_d = i_wdata[RPC_BIT_ADC_IDLE];
        irq0_en_d = i_wdata[RPC_BIT_IRQ0_EN];
        irq1_en_d = i_wdata[RPC_BIT_IRQ1_EN];
      end
      // Converter idle is a one-shot mode
      if (idle_request_bit_q && adc_idle_q && i_adc_done) begin
        adc_idle_d = 1'b0;
      end
      if (i_rd) begin
        if (hit(i_addr, RPC_OFS_POWER_CTRL)) begin
          rdata_d[RPC_BIT_IDLE] = idle_request_bit_q;
          rdata_d[RPC_BIT_PWRDN] = powerdown_request_bit_q;
          rdata_d[RPC_BIT_GF0] = general_flag_zero_q;
          rdata_d[RPC_BIT_GF1] = general_flag_one_q;
        end else if (hit(i_addr, RPC_OFS_MODE_CTRL)) begin
          rdata_d[RPC_BIT_ADC_IDLE] = adc_idle_q;
          rdata_d[RPC_BIT_IRQ0_EN] = irq0_en_q;
          rdata_d[RPC_BIT_IRQ1_EN] = irq1_en_q;
        end else if (hit(i_addr, RPC_OFS_STATUS)) begin
          rdata_d[RPC_BIT_ST_RESUME] = (state_q == RPC_ST_RESUME);
          rdata_d[RPC_BIT_ST_CORE_RST] = (state_q == RPC_ST_CORE_RST);
          rdata_d[RPC_BIT_ST_PD_WAKE] = (state_q == RPC_ST_PD_WAKE);
          rdata_d[RPC_BIT_ST_WDT_OUT] = wdt_drive_q;
          rdata_d[RPC_BIT_ST_WARM_SEEN] = warm_seen_q;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    general_flag_zero_q <= general_flag_zero_d;
    general_flag_one_q <= general_flag_one_d;
    adc_idle_q <= adc_idle_d;
    irq0_en_q <= irq0_en_d;
    irq1_en_q <= irq1_en_d;
    rdata_q <= rdata_d;
  end

  // Watchdog reset pulse driven out on the pin
  always_comb begin
    wdt_drive_d = wdt_drive_q;
    wdt_cnt_d = wdt_cnt_q;
    if (i_rst) begin
      wdt_drive_d = 1'b0;
      wdt_cnt_d = '0;
    end else if (wdt_drive_q) begin
      if (wdt_cnt_q == WDT_LAST) begin
        wdt_drive_d = 1'b0;
        wdt_cnt_d = '0;
      end else begin
        wdt_cnt_d = wdt_cnt_q + 1'b1;
      end
    end else if (i_watchdog_timer_expire) begin
      wdt_drive_d = 1'b1;
      wdt_cnt_d = '0;
    end
  end

  always_ff @(posedge i_clk) begin
    wdt_drive_q <= wdt_drive_d;
    wdt_cnt_q <= wdt_cnt_d;
  end

  // Reset sequencing: short resume window, then core reset
  always_comb begin
    state_d = state_q;
    warm_cnt_d = warm_cnt_q;
    warm_seen_d = warm_seen_q;
    cpu_rst_d = cpu_rst_q;
    ram_block_d = ram_block_q;
    vector_d = vector_q;
    if (i_rst) begin
      state_d = RPC_ST_CORE_RST;
      warm_cnt_d = '0;
      warm_seen_d = 1'b0;
      cpu_rst_d = 1'b1;
      ram_block_d = 1'b0;
      vector_d = RPC_RESET_VECTOR;
    end else begin
      case (state_q)
        RPC_ST_RUN: begin
          warm_cnt_d = '0;
          if (rst_pin_s) begin
            // Core keeps running until the pulse proves valid
            state_d = RPC_ST_RESUME;
            ram_block_d = 1'b1;
          end else if (powerdown_request_bit_q && irq_wake) begin
            state_d = RPC_ST_PD_WAKE;
          end
        end
        RPC_ST_RESUME: begin
          if (!rst_pin_s) begin
            // Too short: not a reset, core carries on
            state_d = RPC_ST_RUN;
            ram_block_d = 1'b0;
          end else if (warm_cnt_q == WARM_LAST) begin
            state_d = RPC_ST_CORE_RST;
            warm_seen_d = 1'b1;
            cpu_rst_d = 1'b1;
            ram_block_d = 1'b0;
            vector_d = RPC_RESET_VECTOR;
          end else begin
            warm_cnt_d = warm_cnt_q + 1'b1;
          end
        end
        RPC_ST_CORE_RST: begin
          warm_cnt_d = '0;
          if (!rst_pin_s) begin
            state_d = RPC_ST_RUN;
            cpu_rst_d = 1'b0;
          end
        end
        RPC_ST_PD_WAKE: begin
          if (rst_pin_s) begin
            state_d = RPC_ST_RESUME;
            ram_block_d = 1'b1;
          end else if (irq_pins_released) begin
            // Oscillator settles while the pin is held
            state_d = RPC_ST_RUN;
          end
        end
        default: begin
          state_d = RPC_ST_CORE_RST;
          cpu_rst_d = 1'b1;
          ram_block_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    state_q <= state_d;
    warm_cnt_q <= warm_cnt_d;
    warm_seen_q <= warm_seen_d;
    cpu_rst_q <= cpu_rst_d;
    ram_block_q <= ram_block_d;
    vector_q <= vector_d;
  end

  assign o_rst_pin_o = wdt_drive_q;
  assign o_rst_pin_oe = wdt_drive_q;
  assign o_rdata = rdata_q;
  assign o_osc_en = osc_en_q;
  assign o_cpu_clk_en = cpu_clk_en_q;
  assign o_periph_clk_en = periph_clk_en_q;
  assign o_state_hold = hold_q;
  assign o_cpu_rst = cpu_rst_q;
  assign o_reset_vector = vector_q;
  assign o_ram_block = ram_block_q;

endmodule

// file: sim/rpc_reset_idle_powerdown_ctrl_asserts.sv
`timescale 1ns/100ps
module rpc_asserts
  import rpc_pkg::*;
#(
  parameter int unsigned WARM_RST_MIN_CYC = 24,
  parameter int unsigned WDT_PULSE_CYC = 96
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins and events
  input wire logic i_rst_pin,
  input wire logic o_rst_pin_o,
  input wire logic o_rst_pin_oe,
  input wire logic i_ext_irq_zero_pin_n,
  input wire logic i_ext_irq_one_pin_n,
  input wire logic i_watchdog_timer_expire,
  input wire logic i_irq_pending,
  // Register port
  input wire logic [RPC_ADDR_W-1:0] i_addr,
  input wire logic [RPC_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  // Controls toward the core
  input wire logic o_osc_en,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_state_hold,
  input wire logic o_cpu_rst,
  input wire logic [15:0] o_reset_vector,
  input wire logic o_ram_block
);
  logic [7:0] wdt_cnt_q, wdt_cnt_d, pin_cnt_q, pin_cnt_d;
  logic pd_wr;
  // The pin counter saturates so a stuck pin cannot wrap into a false match; the watchdog counter wraps
  always_comb begin
    wdt_cnt_d = o_rst_pin_oe ? wdt_cnt_q + 8'h01 : 8'h00;
    pin_cnt_d = !i_rst_pin ? 8'h00 : pin_cnt_q + {7'h00, pin_cnt_q != 8'hff};
    pd_wr = i_wr && i_addr == RPC_OFS_POWER_CTRL && i_wdata[RPC_BIT_PWRDN];
  end
  always_ff @(posedge i_clk) begin
    wdt_cnt_q <= i_rst ? 8'h00 : wdt_cnt_d;
    pin_cnt_q <= i_rst ? 8'h00 : pin_cnt_d;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_wake_wait; o_osc_en && o_state_hold; endsequence
  sequence s_wake_end; !o_state_hold && !i_rst_pin; endsequence
  property p_wdt_start; i_watchdog_timer_expire && !o_rst_pin_oe |=> o_rst_pin_oe && o_rst_pin_o; endproperty
  property p_wdt_len; $fell(o_rst_pin_oe) |-> wdt_cnt_q == WDT_PULSE_CYC; endproperty
  property p_pin_force; i_rst_pin |-> o_osc_en && o_cpu_clk_en && o_periph_clk_en && !o_state_hold;
  endproperty
  // Pin may already be low when core reset rises, so look one edge back
  property p_warm_min; $rose(o_cpu_rst) |-> $past(pin_cnt_q) >= WARM_RST_MIN_CYC + 2; endproperty
  property p_warm_max; pin_cnt_q == WARM_RST_MIN_CYC + 6 |-> o_cpu_rst; endproperty
  property p_ram; $rose(o_ram_block) |-> !o_cpu_rst && pin_cnt_q >= 8'h02 && pin_cnt_q <= 8'h05;
  endproperty
  property p_vector; o_cpu_rst |-> o_reset_vector == RPC_RESET_VECTOR; endproperty
  property p_pd_enter; pd_wr && !i_rst_pin |=> !o_osc_en && !o_cpu_clk_en && o_state_hold; endproperty
  property p_pd_hold; !o_osc_en |-> o_state_hold && !o_cpu_clk_en && !o_periph_clk_en; endproperty
  property p_pd_exit; $rose(o_osc_en) && !$past(i_rst) |->
    i_rst_pin || !i_ext_irq_zero_pin_n || !i_ext_irq_one_pin_n; endproperty
  property p_wake_release; s_wake_wait ##1 s_wake_end |-> i_ext_irq_zero_pin_n && i_ext_irq_one_pin_n;
  endproperty
  property p_idle_irq; o_osc_en && !o_cpu_clk_en && !o_state_hold && !o_cpu_rst && !i_rst_pin
    && i_irq_pending && !i_wr |=> o_cpu_clk_en; endproperty
  a_wdt_start: assert property (p_wdt_start) else $error("watchdog drive not started");
  a_wdt_len: assert property (p_wdt_len) else $error("watchdog drive length wrong");
  a_pin_force: assert property (p_pin_force) else $error("pin did not restore clocks");
  a_warm_min: assert property (p_warm_min) else $error("core reset on short pulse");
  a_warm_max: assert property (p_warm_max) else $error("core reset missing");
  a_ram: assert property (p_ram) else $error("ram block timing wrong");
  a_vector: assert property (p_vector) else $error("reset vector wrong");
  a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");
  a_pd_hold: assert property (p_pd_hold) else $error("clocks run in power-down");
  a_pd_exit: assert property (p_pd_exit) else $error("power-down left without cause");
  a_wake_release: assert property (p_wake_release) else $error("resumed before release");
  a_idle_irq: assert property (p_idle_irq) else $error("interrupt did not end idle");
endmodule

// file: sim/rpc_board_model.sv
`timescale 1ns/100ps
module rpc_board_model #(
  parameter int unsigned WAKE_HOLD = 20
) (
  // Clock
  input wire logic i_clk,
  // Bench controls
  input wire logic i_press,
  input wire logic i_wake_req,
  input wire logic i_wake_sel,
  // Device reset pin drive
  input wire logic i_drv_o,
  input wire logic i_drv_oe,
  // Board wires
  output logic o_rst_pin,
  output logic o_irq_zero_n,
  output logic o_irq_one_n
);
  int unsigned hold_q = 0;
  logic sel_q = 1'b0;
  // Pull-down on the reset net, so a released pin reads low
  assign o_rst_pin = i_press | (i_drv_oe & i_drv_o);
  // Wake line held as a level long enough for the oscillator to settle
  always_ff @(posedge i_clk) begin
    if (i_wake_req) begin
      hold_q <= WAKE_HOLD;
      sel_q <= i_wake_sel;
    end else if (hold_q != 0) begin
      hold_q <= hold_q - 1;
    end
  end
  // Pull-ups on both interrupt lines
  assign o_irq_zero_n = !(hold_q != 0 && !sel_q);
  assign o_irq_one_n = !(hold_q != 0 && sel_q);
endmodule

// file: sim/tb_rpc_reset_idle_powerdown_ctrl.sv
`timescale 1ns/100ps
`define CHK(name, exp, got) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected %s: expected %h, seen %h", name, exp, got); end end
module tb_rpc_reset_idle_powerdown_ctrl;
  import rpc_pkg::*;
  localparam int unsigned WARM = 6;
  localparam int unsigned WDT = 8;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_watchdog_timer_expire = 1'b0, i_irq_pending = 1'b0, i_adc_done = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic i_wr = 1'b0, i_rd = 1'b0, press = 1'b0, wake_req = 1'b0, wake_sel = 1'b0;
  logic rst_pin, pin_o, pin_oe, irq0_n, irq1_n, o_osc_en, o_cpu_clk_en, o_periph_clk_en;
  logic o_state_hold, o_cpu_rst, o_ram_block, ram_seen, rst_seen;
  logic [15:0] o_reset_vector;
  int errors = 0;
  int samples_checked = 0;
  always #12.5 i_clk = !i_clk;
  always @(posedge i_clk) begin
    if (o_ram_block) ram_seen <= 1'b1;
    if (o_cpu_rst) rst_seen <= 1'b1;
  end
  rpc_reset_idle_powerdown_ctrl #(.WARM_RST_MIN_CYC(WARM), .WDT_PULSE_CYC(WDT))
  i_rpc_reset_idle_powerdown_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_rst_pin(rst_pin),
    .o_rst_pin_o(pin_o), .o_rst_pin_oe(pin_oe), .i_ext_irq_zero_pin_n(irq0_n),
    .i_ext_irq_one_pin_n(irq1_n), .i_watchdog_timer_expire(i_watchdog_timer_expire),
    .i_irq_pending(i_irq_pending), .i_adc_done(i_adc_done), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_osc_en(o_osc_en),
    .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
    .o_state_hold(o_state_hold), .o_cpu_rst(o_cpu_rst), .o_reset_vector(o_reset_vector),
    .o_ram_block(o_ram_block));
  rpc_board_model #(.WAKE_HOLD(20)) i_rpc_board_model (.i_clk(i_clk), .i_press(press),
    .i_wake_req(wake_req), .i_wake_sel(wake_sel), .i_drv_o(pin_o), .i_drv_oe(pin_oe),
    .o_rst_pin(rst_pin), .o_irq_zero_n(irq0_n), .o_irq_one_n(irq1_n));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk) begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
    end
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk) begin
      i_addr <= a;
      i_rd <= 1'b1;
    end
    @(posedge i_clk) i_rd <= 1'b0;
    #1 `CHK("read data", exp, o_rdata)
  endtask
  task automatic wake(input logic s);
    @(posedge i_clk) begin
      wake_sel <= s;
      wake_req <= 1'b1;
    end
    @(posedge i_clk) wake_req <= 1'b0;
  endtask
  task automatic wait_rst;
    for (int n = 0; n < 20 && o_cpu_rst; n++) @(posedge i_clk);
    #1 `CHK("core reset released", 1'b0, o_cpu_rst)
  endtask
  task automatic close_out;
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_regs;
    wr(RPC_OFS_POWER_CTRL, 8'h0c);
    rd(RPC_OFS_POWER_CTRL, 8'h0c);
    wr(RPC_OFS_POWER_CTRL, 8'h04);
    wr(8'h8f, 8'hff);
    rd(8'h8f, 8'h00);
    rd(RPC_OFS_POWER_CTRL, 8'h04);
    wr(RPC_OFS_POWER_CTRL, 8'h00);
  endtask
  task automatic t_idle;
    wr(RPC_OFS_POWER_CTRL, 8'h01);
    #1 `CHK("cpu clock in idle", 1'b0, o_cpu_clk_en)
    @(posedge i_clk) i_irq_pending <= 1'b1;
    @(posedge i_clk) i_irq_pending <= 1'b0;
    #1 `CHK("cpu clock after irq", 1'b1, o_cpu_clk_en)
    rd(RPC_OFS_POWER_CTRL, 8'h00);
    wr(RPC_OFS_MODE_CTRL, 8'h01);
    wr(RPC_OFS_POWER_CTRL, 8'h01);
    @(posedge i_clk) i_adc_done <= 1'b1;
    @(posedge i_clk) i_adc_done <= 1'b0;
    #1 `CHK("cpu clock after conversion", 1'b1, o_cpu_clk_en)
    rd(RPC_OFS_MODE_CTRL, 8'h00);
  endtask
  task automatic t_warm;
    wr(RPC_OFS_POWER_CTRL, 8'h01);
    @(posedge i_clk) press <= 1'b1;
    #1 `CHK("cpu clock on pin", 1'b1, o_cpu_clk_en)
    ram_seen = 1'b0;
    rst_seen = 1'b0;
    // Bus stays quiet while the core resumes
    cyc(WARM - 2);
    @(posedge i_clk) press <= 1'b0;
    cyc(8);
    #1 `CHK("ram blocked on resume", 1'b1, ram_seen)
    `CHK("core reset on short pulse", 1'b0, rst_seen)
    rd(RPC_OFS_POWER_CTRL, 8'h00);
    @(posedge i_clk) press <= 1'b1;
    cyc(WARM + 10);
    #1 `CHK("core reset", 1'b1, o_cpu_rst)
    `CHK("reset vector", RPC_RESET_VECTOR, o_reset_vector)
    `CHK("ram block in reset", 1'b0, o_ram_block)
    rd(RPC_OFS_STATUS, 8'h12);
    @(posedge i_clk) press <= 1'b0;
    wait_rst;
  endtask
  task automatic t_pd(input logic sel);
    wr(RPC_OFS_MODE_CTRL, sel ? 8'h04 : 8'h02);
    wr(RPC_OFS_POWER_CTRL, 8'h02);
    #1 `CHK("osc in power-down", 1'b0, o_osc_en)
    `CHK("periph clock in power-down", 1'b0, o_periph_clk_en)
    `CHK("state hold", 1'b1, o_state_hold)
    wake(!sel);
    cyc(40);
    #1 `CHK("osc after disabled pin", 1'b0, o_osc_en)
    wake(sel);
    for (int n = 0; n < 10 && !o_osc_en; n++) @(posedge i_clk);
    #1 `CHK("osc after wake", 1'b1, o_osc_en)
    `CHK("cpu clock while pin held", 1'b0, o_cpu_clk_en)
    `CHK("hold while pin held", 1'b1, o_state_hold)
    for (int n = 0; n < 60 && o_state_hold; n++) @(posedge i_clk);
    #1 `CHK("irq pins at resume", 2'b11, {irq0_n, irq1_n})
    `CHK("cpu clock at resume", 1'b1, o_cpu_clk_en)
    rd(RPC_OFS_POWER_CTRL, 8'h00);
  endtask
  task automatic t_pd_pin;
    wr(RPC_OFS_POWER_CTRL, 8'h02);
    @(posedge i_clk) press <= 1'b1;
    #1 `CHK("osc on pin", 1'b1, o_osc_en)
    `CHK("periph clock on pin", 1'b1, o_periph_clk_en)
    cyc(WARM + 10);
    @(posedge i_clk) press <= 1'b0;
    wait_rst;
    rd(RPC_OFS_POWER_CTRL, 8'h00);
  endtask
  task automatic t_wdt;
    int hi;
    hi = 0;
    @(posedge i_clk) i_watchdog_timer_expire <= 1'b1;
    @(posedge i_clk) i_watchdog_timer_expire <= 1'b0;
    #1 `CHK("pin drive", 2'b11, {pin_oe, pin_o})
    // A second expiry mid-pulse must not stretch it
    while (pin_oe && hi < 200) begin
      @(posedge i_clk) i_watchdog_timer_expire <= (hi == 3);
      #1 hi++;
    end
    `CHK("pin drive length", WDT, hi)
    cyc(40);
    wait_rst;
  endtask
  initial begin
    cyc(2);
    i_rst <= 1'b0;
    cyc(5);
    t_regs;
    t_idle;
    t_warm;
    t_pd(1'b0);
    t_pd(1'b1);
    t_pd_pin;
    t_wdt;
    close_out;
  end
  initial begin
    cyc(5000);
    errors++;
    close_out;
  end
endmodule
bind rpc_reset_idle_powerdown_ctrl rpc_asserts #(.WARM_RST_MIN_CYC(WARM_RST_MIN_CYC),
  .WDT_PULSE_CYC(WDT_PULSE_CYC)) i_rpc_asserts (.i_clk(i_clk), .i_rst(i_rst),
  .i_rst_pin(i_rst_pin), .o_rst_pin_o(o_rst_pin_o), .o_rst_pin_oe(o_rst_pin_oe),
  .i_ext_irq_zero_pin_n(i_ext_irq_zero_pin_n), .i_ext_irq_one_pin_n(i_ext_irq_one_pin_n),
  .i_watchdog_timer_expire(i_watchdog_timer_expire), .i_irq_pending(i_irq_pending),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .o_osc_en(o_osc_en),
  .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en),
  .o_state_hold(o_state_hold), .o_cpu_rst(o_cpu_rst), .o_reset_vector(o_reset_vector),
  .o_ram_block(o_ram_block));
